//--- core/carrier_regs.v
/*
 * Carrier control and status register bank: register decode, interrupt
 * pending/enable/level relay with rotating priority, A24 window decode,
 * module access self-acknowledge and timeout flag, software reset pulse.
 * Assumes a single board clock; bus strobes come from logic on this clock,
 * module request, error and ack lines come from pins and are synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "carrier_regs_defs.vh"

// How it works
// RULE1: Auto-clear set: pending follows live requests
// RULE2: Ack disabled: empty slot left unanswered
// RULE3: Ack enabled: self-acknowledge and flag timeout
// RULE4: Timeout flag cleared by status read
// RULE5: Soft reset bit gives 1us pulse
// RULE6: Global enable gates all forwarding
// RULE7: Global pending reflects any pending request
// RULE8: Forward only globally and individually enabled requests
// RULE9: Three-bit level selects bus request line
// RULE10: Error bit is OR of module errors
// RULE11: Error register upper bits read zero
// RULE12: Per-slot memory enable gates A24 only
// RULE13: Size code selects compared address bits
// RULE14: Base bits stored fully; size resets 1MB
// RULE15: Memory answer needs enable and window hit
// RULE16: Software keeps enabled windows non-overlapping
// RULE17: Eight request enables, two per slot
// RULE18: Clear register write-one clears pending
// RULE19: Last serviced request gets lowest priority
// RULE20: Acknowledge selects slot, A1 picks request
// RULE21: Writes to read-only bits are ignored
module carrier_regs #(
	parameter SLOTS       = 4,
	parameter ACK_TIMEOUT = `ACK_TIMEOUT_CYCLES
) (
	// Clock and reset
	input  wire        clock,
	input  wire        resetn,
	// Register access from the host bus decoder
	input  wire        reg_sel,
	input  wire        reg_write,
	input  wire [7:0]  reg_offset,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_q,
	output reg         reg_ack_q,
	// Module access (I/O, ID, memory) from the host bus decoder
	input  wire        mod_start,
	input  wire        mod_end,
	input  wire [1:0]  mod_slot,
	input  wire        mem_sel,
	input  wire [23:0] mem_addr,
	output reg  [3:0]  mem_hit_q,
	output reg         mem_valid_q,
	output reg         self_ack_q,
	// Module pins
	input  wire [7:0]  mod_req,
	input  wire [3:0]  mod_error,
	input  wire [3:0]  mod_ack,
	// Host interrupt request and acknowledge
	output reg  [7:1]  bus_irq_q,
	input  wire        iack_start,
	input  wire [2:0]  iack_level,
	output reg         iack_match_q,
	output reg  [3:0]  int_sel_q,
	output reg         int_a1_q,
	// Internal reset to modules and board
	output reg         soft_reset_q
);

	reg [7:0]  req_s1_q, req_s2_q;
	reg [3:0]  err_s1_q, err_s2_q;
	reg [3:0]  ack_s1_q, ack_s2_q;
	reg        auto_clear_q, ack_disable_q, timed_out_q, global_en_q;
	reg [2:0]  level_q;
	reg [3:0]  mem_en_q;
	reg [31:0] window_q;
	reg [7:0]  req_en_q;
	reg [7:0]  pend_q;
	reg [2:0]  last_q;
	reg [9:0]  rst_cnt_q;
	reg        busy_q;
	reg [7:0]  wait_q;
	reg [7:0]  rdata_d;
	reg [7:0]  pend_d;
	reg [3:0]  hit_d;
	reg [2:0]  pick_d;
	reg        pick_ok_d;
	integer    i;
	wire [3:0] win_hit;

	localparam [9:0] RESET_LEN = `SOFT_RESET_CYCLES;

	wire wr = reg_sel & reg_write;
	wire rd = reg_sel & ~reg_write;
	wire [7:0] pend_view = auto_clear_q ? req_s2_q : pend_q;              // [RULE1]
	wire any_pend = |pend_view;                                            // [RULE7]
	wire [7:0] serve = pend_view & req_en_q & {8{global_en_q}};            // [RULE6] [RULE8]
	wire soft_wr = wr && reg_offset == `OFS_BOARD_STATUS_CONTROL &&
		reg_wdata[`BIT_SOFT_RESET];
	wire timeout_now = busy_q && !mod_start && !mod_end && !ack_s2_q[mod_slot] &&
		wait_q == ACK_TIMEOUT[7:0];

	// Module pins are asynchronous to the board clock
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			req_s1_q <= 8'h00;
			req_s2_q <= 8'h00;
			err_s1_q <= 4'h0;
			err_s2_q <= 4'h0;
			ack_s1_q <= 4'h0;
			ack_s2_q <= 4'h0;
		end else begin
			req_s1_q <= mod_req;
			req_s2_q <= req_s1_q;
			err_s1_q <= mod_error;
			err_s2_q <= err_s1_q;
			ack_s1_q <= mod_ack;
			ack_s2_q <= ack_s1_q;
		end
	end

	// Read multiplexer
	always @* begin
		rdata_d = 8'h00;
		if (reg_offset == `OFS_BOARD_STATUS_CONTROL) begin
			rdata_d = {auto_clear_q, ack_disable_q, timed_out_q, 1'b0,
				global_en_q, any_pend, 2'b00};                                 // [RULE5] [RULE7]
		end else if (reg_offset == `OFS_INTERRUPT_LEVEL_SELECT) begin
			rdata_d = {5'h00, level_q};                                      // [RULE9]
		end else if (reg_offset == `OFS_MODULE_ERROR_SUMMARY) begin
			rdata_d = {7'h00, |err_s2_q};                                    // [RULE10] [RULE11]
		end else if (reg_offset == `OFS_MEMORY_WINDOW_ENABLE) begin
			rdata_d = {4'h0, mem_en_q};
		end else if (reg_offset == `OFS_SLOT_A_MEMORY_WINDOW) begin
			rdata_d = window_q[7:0];
		end else if (reg_offset == `OFS_SLOT_B_MEMORY_WINDOW) begin
			rdata_d = window_q[15:8];
		end else if (reg_offset == `OFS_SLOT_C_MEMORY_WINDOW) begin
			rdata_d = window_q[23:16];
		end else if (reg_offset == `OFS_SLOT_D_MEMORY_WINDOW) begin
			rdata_d = window_q[31:24];
		end else if (reg_offset == `OFS_REQUEST_ENABLE_MASK) begin
			rdata_d = req_en_q;                                              // [RULE17]
		end else if (reg_offset == `OFS_REQUEST_PENDING_STATUS) begin
			rdata_d = pend_view;
		end
	end

	// Pending latch: new requests win over a same-cycle clear
	always @* begin
		pend_d = pend_q;
		if (wr && reg_offset == `OFS_REQUEST_CLEAR)
			pend_d = pend_d & ~reg_wdata;                                  // [RULE18]
		pend_d = pend_d | req_s2_q;
	end

	// Rotating priority: search starts just after the last served request
	always @* begin
		pick_d = 3'h0;
		pick_ok_d = 1'b0;
		for (i = 8; i >= 1; i = i - 1) begin
			if (serve[(last_q + i) % 8]) begin
				pick_d = last_q + i[2:0];                                  // [RULE19]
				pick_ok_d = 1'b1;
			end
		end
	end

	// Window decode, one comparator per slot
	genvar g;
	generate
		for (g = 0; g < SLOTS; g = g + 1) begin : g_window
			wire [7:0] win = window_q[g*8 +: 8];
			// Larger windows compare fewer base bits; the unused ones stay stored
			assign win_hit[g] = (win[1:0] == 2'b00) ? (mem_addr[23:20] == win[7:4]) :
				(win[1:0] == 2'b01) ? (mem_addr[23:21] == win[7:5]) :
				(win[1:0] == 2'b10) ? (mem_addr[23:22] == win[7:6]) :
				(mem_addr[23] == win[7]);                                  // [RULE13]
		end
	endgenerate

	// Overlapping enabled windows would raise two hits; software keeps them apart
	always @* begin
		hit_d = win_hit & mem_en_q;                                        // [RULE12] [RULE15]
	end

	// Register bus answer: one cycle after the strobe, read data only on reads
	// Idle cycles return zero so a stale value never looks like an answer
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_ack_q   <= 1'b0;
			reg_rdata_q <= 8'h00;
		end else begin
			reg_ack_q   <= reg_sel;
			reg_rdata_q <= rd ? rdata_d : 8'h00;
		end
	end

	// Writable fields; read-only registers have no write branch at all
	// Window bits 3:2 are not stored, so they read back as zero
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			auto_clear_q  <= 1'b0;
			ack_disable_q <= 1'b0;
			global_en_q   <= 1'b0;
			level_q       <= `RST_LEVEL;
			mem_en_q      <= 4'h0;
			window_q      <= {4{`RST_WINDOW}};
			req_en_q      <= `RST_BYTE;
		end else if (wr) begin                                             // [RULE21]
				if (reg_offset == `OFS_BOARD_STATUS_CONTROL) begin
					auto_clear_q  <= reg_wdata[`BIT_AUTO_CLEAR];
					ack_disable_q <= reg_wdata[`BIT_ACK_DISABLE];
					global_en_q   <= reg_wdata[`BIT_GLOBAL_EN];          // [RULE6]
				end else if (reg_offset == `OFS_INTERRUPT_LEVEL_SELECT) begin
					level_q <= reg_wdata[2:0];                             // [RULE9]
				end else if (reg_offset == `OFS_MEMORY_WINDOW_ENABLE) begin
					mem_en_q <= reg_wdata[3:0];                            // [RULE12]
				end else if (reg_offset == `OFS_SLOT_A_MEMORY_WINDOW) begin
					window_q[7:0] <= reg_wdata & 8'hf3;                    // [RULE14]
				end else if (reg_offset == `OFS_SLOT_B_MEMORY_WINDOW) begin
					window_q[15:8] <= reg_wdata & 8'hf3;
				end else if (reg_offset == `OFS_SLOT_C_MEMORY_WINDOW) begin
					window_q[23:16] <= reg_wdata & 8'hf3;
				end else if (reg_offset == `OFS_SLOT_D_MEMORY_WINDOW) begin
					window_q[31:24] <= reg_wdata & 8'hf3;
				end else if (reg_offset == `OFS_REQUEST_ENABLE_MASK) begin
					req_en_q <= reg_wdata;                                 // [RULE17]
				end
		end
	end

	// Pending latch; with auto-clear nothing is held and the live view is read
	// Clearing auto-clear later starts from an empty latch, not from old events
	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			pend_q <= `RST_BYTE;
		else
			pend_q <= auto_clear_q ? 8'h00 : pend_d;                       // [RULE1]
	end

	// Software reset pulse; a write of 0 or a read does nothing
	// A second write during the pulse restarts the full length
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_cnt_q    <= 10'h000;
			soft_reset_q <= 1'b0;
		end else if (soft_wr) begin
			rst_cnt_q    <= RESET_LEN;                                     // [RULE5]
			soft_reset_q <= 1'b1;
		end else if (rst_cnt_q != 10'h000) begin
			rst_cnt_q    <= rst_cnt_q - 10'h001;
			soft_reset_q <= rst_cnt_q != 10'h001;
		end
	end

	// Module access: wait for the module, else time out
	// The wait counter stops at the limit, so it never wraps during an access
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy_q     <= 1'b0;
			wait_q     <= 8'h00;
			self_ack_q <= 1'b0;
		end else begin
			self_ack_q <= 1'b0;
			if (mod_start) begin
				busy_q <= 1'b1;
				wait_q <= 8'h00;
			end else if (busy_q) begin
				if (mod_end || ack_s2_q[mod_slot]) begin
					busy_q <= 1'b0;
				end else if (timeout_now) begin
					busy_q     <= 1'b0;
					// With self-acknowledge off the host bus times out instead
					self_ack_q <= ~ack_disable_q;                          // [RULE2] [RULE3]
				end else begin
					wait_q <= wait_q + 8'h01;
				end
			end
		end
	end

	// A timeout wins over a same-cycle status read
	// The flag is set even with self-acknowledge off, so software can still see it
	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			timed_out_q <= 1'b0;
		else if (timeout_now)
			timed_out_q <= 1'b1;                                           // [RULE3] [RULE4]
		else if (rd && reg_offset == `OFS_BOARD_STATUS_CONTROL)
			timed_out_q <= 1'b0;                                           // [RULE4]
	end

	// Memory decode, registered; nothing is hit outside a memory access
	// I/O and ID accesses never raise mem_sel, so the enables leave them alone
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_hit_q   <= 4'h0;
			mem_valid_q <= 1'b0;
		end else begin
			mem_hit_q   <= mem_sel ? hit_d : 4'h0;
			mem_valid_q <= mem_sel & (|hit_d);                             // [RULE15]
		end
	end

	// Relay only; level 0 raises no line
	// The line follows the served set, so it drops once nothing is pending
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus_irq_q <= 7'h00;
		end else begin
			bus_irq_q <= 7'h00;
			if (pick_ok_d && level_q != 3'h0)
				bus_irq_q[level_q] <= 1'b1;                                // [RULE8] [RULE9]
		end
	end

	// Interrupt acknowledge: a foreign level is passed on, not consumed
	// A1 holds until the next match so the module sees a steady request number
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			iack_match_q <= 1'b0;
			int_sel_q    <= 4'h0;
			int_a1_q     <= 1'b0;
			last_q       <= 3'h0;
		end else begin
			iack_match_q <= 1'b0;
			int_sel_q    <= 4'h0;
			if (iack_start && pick_ok_d && iack_level == level_q &&
				level_q != 3'h0) begin
				iack_match_q           <= 1'b1;
				int_sel_q[pick_d[2:1]] <= 1'b1;                            // [RULE20]
				int_a1_q               <= pick_d[0];
				last_q                 <= pick_d;                          // [RULE19]
			end
		end
	end

endmodule
`default_nettype wire

//--- core/carrier_regs_defs.vh
/*
 * Register offsets, field positions, reset values and timing for the
 * carrier control register bank.
 * Assumes short I/O offsets relative to the board base (odd bytes only).
 */
`ifndef CARRIER_REGS_DEFS_VH
`define CARRIER_REGS_DEFS_VH

`define OFS_BOARD_STATUS_CONTROL   8'hc1
`define OFS_INTERRUPT_LEVEL_SELECT 8'hc3
`define OFS_MODULE_ERROR_SUMMARY   8'hc5
`define OFS_MEMORY_WINDOW_ENABLE   8'hc7
`define OFS_SLOT_A_MEMORY_WINDOW   8'hd1
`define OFS_SLOT_B_MEMORY_WINDOW   8'hd3
`define OFS_SLOT_C_MEMORY_WINDOW   8'hd5
`define OFS_SLOT_D_MEMORY_WINDOW   8'hd7
`define OFS_REQUEST_ENABLE_MASK    8'he1
`define OFS_REQUEST_PENDING_STATUS 8'he3
`define OFS_REQUEST_CLEAR          8'he5

`define BIT_AUTO_CLEAR   7
`define BIT_ACK_DISABLE  6
`define BIT_TIMED_OUT    5
`define BIT_SOFT_RESET   4
`define BIT_GLOBAL_EN    3
`define BIT_GLOBAL_PEND  2

`define RST_BYTE         8'h00
`define RST_LEVEL        3'h0
`define RST_WINDOW       8'h00

`define SOFT_RESET_NS    1000
`define CLOCK_NS         4
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`define ACK_TIMEOUT_CYCLES 64

`endif

//--- verif/carrier_regs_monitor.sv
/* Port checker for the carrier register bank, bound to its top module.
   Assumes one board clock and the active-low asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module carrier_regs_monitor (
	// Clock and register access
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       reg_sel,
	input wire logic       reg_write,
	input wire logic [7:0] reg_offset,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       reg_ack_q,
	// Decode, requests and soft reset
	input wire logic       mem_sel,
	input wire logic [3:0] mem_hit_q,
	input wire logic       mem_valid_q,
	input wire logic [7:1] bus_irq_q,
	input wire logic       iack_start,
	input wire logic       iack_match_q,
	input wire logic [3:0] int_sel_q,
	input wire logic       soft_reset_q
);
	logic [8:0] high_q;
	wire        rd = reg_sel && !reg_write;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// A counter stands in for a repetition far too long to unroll
	always @(posedge clock or negedge resetn) begin
		if (!resetn) high_q <= 9'h000;
		else high_q <= soft_reset_q ? high_q + 9'h001 : 9'h000;
	end
	a_level_onehot: assert property ($onehot0(bus_irq_q))
		else $error("several request levels at once");
	a_error_upper: assert property (rd && reg_offset == 8'hc5 |=> reg_rdata_q[7:1] == 7'h00)
		else $error("error register upper bits set");
	a_soft_cause: assert property ($rose(soft_reset_q) |->
		$past(reg_sel && reg_write && reg_offset == 8'hc1 && reg_wdata[4]))
		else $error("soft reset without its write");
	a_soft_width: assert property ($fell(soft_reset_q) |-> high_q == 9'h0fa)
		else $error("soft reset pulse length wrong");
	a_hit_valid: assert property (mem_valid_q == (mem_hit_q != 4'h0) && $onehot0(mem_hit_q))
		else $error("memory hit flags disagree");
	a_hit_sel: assert property (!mem_sel |=> mem_hit_q == 4'h0)
		else $error("memory hit without memory access");
	a_iack_select: assert property (iack_match_q |-> $onehot(int_sel_q) && $past(iack_start))
		else $error("bad acknowledge select");
	a_iack_irq: assert property (iack_match_q |-> $past(bus_irq_q) != 7'h00)
		else $error("acknowledge taken with no request");
	a_unmapped_zero: assert property (rd && (reg_offset == 8'hc9 || reg_offset == 8'he5) |=>
		reg_ack_q && reg_rdata_q == 8'h00) else $error("unreadable place read nonzero");
	cover property ($fell(soft_reset_q));
	cover property (iack_match_q);
	cover property (mem_valid_q);
endmodule
bind carrier_regs carrier_regs_monitor carrier_regs_monitor_inst (.*);
`default_nettype wire

//--- verif/carrier_regs_tb.sv
/* Bench for the carrier register bank with a slot model.
   Assumes the checker is bound to the design. */
`timescale 1ns/100ps
`default_nettype none
module carrier_regs_tb;
	logic        clock = 1'b0, resetn = 1'b0, reg_sel = 1'b0, reg_write = 1'b0;
	logic        mod_start = 1'b0, mod_end = 1'b0, mem_sel = 1'b0, iack_start = 1'b0;
	logic [7:0]  reg_offset = 8'h00, reg_wdata = 8'h00, mod_req = 8'h00, rd, ex, m;
	logic [1:0]  mod_slot = 2'h0;
	logic [23:0] mem_addr = 24'h000000, a;
	logic [3:0]  mod_error = 4'h0, mod_ack, mem_hit_q, int_sel_q;
	logic [2:0]  iack_level = 3'h0, lvl;
	logic [7:1]  bus_irq_q;
	logic        reg_ack_q, mem_valid_q, self_ack_q, iack_match_q, int_a1_q, soft_reset_q;
	logic [7:0]  reg_rdata_q;
	logic [7:0]  offs [0:11] = '{8'hc1, 8'hc3, 8'hc5, 8'hc7, 8'hd1, 8'hd3, 8'hd5, 8'hd7,
		8'he1, 8'he3, 8'he5, 8'hc9};
	logic [7:0]  wm [0:11] = '{8'hc8, 8'h07, 8'h00, 8'h0f, 8'hf3, 8'hf3, 8'hf3, 8'hf3,
		8'hff, 8'h00, 8'h00, 8'h00};
	logic [7:0]  win [0:3] = '{8'h00, 8'h21, 8'hb3, 8'h42};
	integer      failures = 0, n_tests = 0, seed = 92, i, k, sa;
	carrier_regs #(.ACK_TIMEOUT(16)) carrier_regs_inst (.*);
	slot_model slot_model_inst (.*);
	always #2 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] o, input logic [7:0] d);
		@(posedge clock);
		reg_sel <= 1'b1;
		reg_write <= w;
		reg_offset <= o;
		reg_wdata <= d;
		@(posedge clock);
		reg_sel <= 1'b0;
		#1 rd = reg_rdata_q;
		chk({7'h00, reg_ack_q}, 8'h01);
	endtask
	task automatic rdc(input logic [7:0] o, input logic [7:0] e, input logic [7:0] msk);
		acc(1'b0, o, 8'h00);
		chk(rd & msk, e);
	endtask
	task automatic mod_acc(input logic [1:0] s, input logic [7:0] e);
		@(posedge clock);
		mod_start <= 1'b1;
		mod_slot <= s;
		@(posedge clock);
		mod_start <= 1'b0;
		sa = 0;
		repeat (30) @(posedge clock) #1 sa += self_ack_q;
		@(posedge clock);
		mod_end <= 1'b1;
		@(posedge clock);
		mod_end <= 1'b0;
		chk(sa[7:0], e);
	endtask
	task automatic ack_cycle(input logic [2:0] l);
		@(posedge clock);
		iack_start <= 1'b1;
		iack_level <= l;
		@(posedge clock);
		iack_start <= 1'b0;
		#1 rd = {int_a1_q, iack_match_q, 2'h0, int_sel_q};
	endtask
	// Requests pass two synchronisers before they latch, so allow a few cycles
	task automatic drive_req(input logic [7:0] v);
		@(posedge clock) mod_req <= v;
		repeat (6) @(posedge clock);
		#1;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#50000;
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test;
	end
	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		for (i = 0; i < 12; i++) rdc(offs[i], 8'h00, 8'hff);
		acc(1'b1, 8'hc1, 8'h10);
		for (k = 0; k < 300 && soft_reset_q === 1'b1; k++) @(posedge clock) #1;
		chk(k[7:0], 8'hfa);
		rdc(8'hc1, 8'h00, 8'h10);
		$display("end: reset values and soft reset");
		for (i = 0; i < 40; i++) begin
			k = {$random(seed)} % 12;
			ex = $random(seed);
			if (k == 0) ex[4] = 1'b0;
			acc(1'b1, offs[k], ex);
			rdc(offs[k], ex & wm[k], 8'hff);
		end
		for (i = 0; i < 8; i++) begin
			@(posedge clock) mod_error <= $random(seed);
			repeat (4) @(posedge clock);
			rdc(8'hc5, {7'h00, |mod_error}, 8'hff);
		end
		$display("end: register access");
		for (i = 0; i < 4; i++) acc(1'b1, 8'hd1 + 8'h02 * i[7:0], win[i]);
		@(posedge clock) mem_sel <= 1'b1;
		for (i = 0; i < 128; i++) begin
			if (i % 64 == 0) acc(1'b1, 8'hc7, i < 64 ? 8'h07 : 8'h0f);
			a = $random(seed);
			@(posedge clock) mem_addr <= a;
			@(posedge clock) #1 ex = 8'h00;
			for (k = 0; k < 4; k++)
				ex[k] = (i >= 64 || k < 3) && a[23:20] >> win[k][1:0] == win[k][7:4] >> win[k][1:0];
			chk({3'h0, mem_valid_q, mem_hit_q}, {3'h0, ex[3:0] != 4'h0, ex[3:0]});
		end
		@(posedge clock) mem_sel <= 1'b0;
		$display("end: memory windows");
		acc(1'b1, 8'hc1, 8'h00);
		mod_acc(2'h2, 8'h01);
		rdc(8'hc1, 8'h20, 8'h20);
		rdc(8'hc1, 8'h00, 8'h20);
		mod_acc(2'h0, 8'h00);
		mod_acc(2'h1, 8'h00);
		rdc(8'hc1, 8'h00, 8'h20);
		acc(1'b1, 8'hc1, 8'h40);
		mod_acc(2'h3, 8'h00);
		$display("end: module access");
		lvl = 3'h1 + {$random(seed)} % 7;
		acc(1'b1, 8'hc3, {5'h00, lvl});
		acc(1'b1, 8'he1, 8'hff);
		acc(1'b1, 8'he5, 8'hff);
		acc(1'b1, 8'hc1, 8'h08);
		drive_req(8'h21);
		chk({bus_irq_q, 1'b0}, 8'h01 << lvl);
		m = 8'h00;
		repeat (2) begin
			ack_cycle(lvl);
			chk(rd & 8'h40, 8'h40);
			for (k = 0; k < 4; k++) if (rd[k]) m = m | 8'h01 << (2 * k + rd[7]);
		end
		chk(m, 8'h21);
		ack_cycle(lvl % 7 + 1);
		chk(rd & 8'h40, 8'h00);
		drive_req(8'h00);
		rdc(8'he3, 8'h21, 8'hff);
		acc(1'b1, 8'hc1, 8'h00);
		drive_req(8'h00);
		chk({bus_irq_q, 1'b0}, 8'h00);
		rdc(8'hc1, 8'h04, 8'h0c);
		acc(1'b1, 8'he5, 8'h01);
		rdc(8'he3, 8'h20, 8'hff);
		acc(1'b1, 8'he5, 8'h20);
		rdc(8'hc1, 8'h00, 8'h04);
		acc(1'b1, 8'hc1, 8'h80);
		drive_req(8'h04);
		rdc(8'he3, 8'h04, 8'hff);
		drive_req(8'h00);
		rdc(8'he3, 8'h00, 8'hff);
		$display("end: interrupt relay");
		finish_test;
	end
endmodule
`default_nettype wire

//--- verif/slot_model.sv
/* Module slots: A answers fast, B slowly, C and D are empty.
   Assumes access strobes on the board clock. */
`timescale 1ns/100ps
`default_nettype none
module slot_model (
	// Board side
	input  wire logic       clock,
	input  wire logic       mod_start,
	input  wire logic       mod_end,
	input  wire logic [1:0] mod_slot,
	// Module pins
	output var  logic [3:0] mod_ack = 4'h0
);
	integer n = -1;
	// Ack held until the access ends, as a real module holds it
	always @(posedge clock) begin
		if (mod_end) n <= -1;
		else if (mod_start) n <= mod_slot == 2'h1 ? 12 : (mod_slot == 2'h0 ? 1 : -1);
		else if (n > 0) n <= n - 1;
		mod_ack <= (n == 0 && !mod_end) ? 4'h1 << mod_slot : 4'h0;
	end
endmodule
`default_nettype wire
